// ===== hw/rioc_regs.sv
// Reference input and output channel control registers on AHB-Lite
// Functional notes
// - Detector bypass forces both reference inputs valid for PLL control.
// - Bypass leaves loss-of-signal status on the real detector results.
// - Secondary ground bit selects 50 ohm to ground in diff mode.
// - Primary ground bit selects 50 ohm to ground in diff mode.
// - Secondary diff bit selects 100 ohm differential termination.
// - Primary diff bit selects 100 ohm differential termination.
// - Secondary AC bit enables internal bias; clear leaves it unused.
// - Primary AC bit enables internal bias; clear leaves it unused.
// - Channel 7..4 off bits disable that channel's mux and divider.
// - Pair off bits disable mux and divider of channels 2/3, 0/1.
// - Single-ended channel off bit powers that channel down.
// - Source select routes PLL1 at 0, PLL2 at 1; resets to 1.
// - Format: 0 off, 1 AC diff, 2 HCSL, 3 CMOS; resets to 1.
// - Diff mode: first mode sets tail 4, 6, 8, 16 or 8 mA.
// - CMOS mode: first mode drives positive pin; resets to 2.
// - HCSL mode: second mode sets load tri, 50, 100, 200 ohm.
// - CMOS mode: second mode drives negative pin likewise.
`timescale 1ns/10ps
module rioc_regs (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire logic         pri_detect,
  input  wire logic         sec_detect,
  input  wire logic         pri_diff_mode,
  input  wire logic         sec_diff_mode,
  output rioc_pkg::rioc_ref_t  ref_ctrl_q,
  output logic      [7:0]   chan_mux_div_off_q,
  output logic              single_ended_channel_off_q,
  output rioc_pkg::rioc_out0_t out0_ctrl_q
);
  import rioc_pkg::*;

  logic [7:0]  ref_input_config_q;
  logic [7:0]  ref_input_config_d;
  logic [7:0]  channel_power_down_q;
  logic [7:0]  channel_power_down_d;
  logic [7:0]  output_zero_control_q;
  logic [7:0]  output_zero_control_d;
  logic        wr_pend_q;
  logic [31:0] adr_q;

  // Bus decode
  wire         acc_take;
  wire         hit_ref_wr;
  wire         hit_channel_power_down_wr;
  wire         hit_out0_wr;
  wire [7:0]   rd_val;

  assign acc_take    = hsel & htrans[1] & hready;
  assign hit_ref_wr  = wr_pend_q & (adr_q == ADR_REF_INPUT_CONFIG);
  assign hit_channel_power_down_wr = wr_pend_q & (adr_q == ADR_CHANNEL_POWER_DOWN);
  assign hit_out0_wr = wr_pend_q & (adr_q == ADR_OUTPUT_ZERO_CONTROL);

  // Reserved bits masked on write so they read back zero
  assign ref_input_config_d = hit_ref_wr ?
    (hwdata[7:0] & MSK_REF_INPUT_CONFIG) : ref_input_config_q;
  assign channel_power_down_d = hit_channel_power_down_wr ?
    (hwdata[7:0] & MSK_CHANNEL_POWER_DOWN) : channel_power_down_q;
  assign output_zero_control_d = hit_out0_wr ?
    (hwdata[7:0] & MSK_OUTPUT_ZERO_CONTROL) : output_zero_control_q;

  // Read data from next values so a read right after a write sees it
  assign rd_val =
    (haddr == ADR_REF_INPUT_CONFIG)    ? ref_input_config_d    :
    (haddr == ADR_CHANNEL_POWER_DOWN)  ? channel_power_down_d  :
    (haddr == ADR_OUTPUT_ZERO_CONTROL) ? output_zero_control_d :
    8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      adr_q     <= 32'h00000000;
    end else begin
      wr_pend_q <= acc_take & hwrite;
      if (acc_take) begin
        adr_q <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc_take & ~hwrite) begin
        hrdata <= {24'h000000, rd_val};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_input_config_q    <= RST_REF_INPUT_CONFIG;
      channel_power_down_q  <= RST_CHANNEL_POWER_DOWN;
      output_zero_control_q <= RST_OUTPUT_ZERO_CONTROL;
    end else begin
      ref_input_config_q    <= ref_input_config_d;
      channel_power_down_q  <= channel_power_down_d;
      output_zero_control_q <= output_zero_control_d;
    end
  end

  // Reference input controls
  wire        byp;
  rioc_ref_t  ref_d;

  assign byp = ref_input_config_q[POS_DETECTOR_BYPASS];
  assign ref_d.pri_valid = byp | pri_detect;
  assign ref_d.sec_valid = byp | sec_detect;
  assign ref_d.pri_los   = ~pri_detect;
  assign ref_d.sec_los   = ~sec_detect;
  assign ref_d.secondary_ground_term = sec_diff_mode &
    ref_input_config_q[POS_SECONDARY_GROUND_TERM];
  assign ref_d.primary_ground_term = pri_diff_mode &
    ref_input_config_q[POS_PRIMARY_GROUND_TERM];
  assign ref_d.secondary_diff_term = sec_diff_mode &
    ref_input_config_q[POS_SECONDARY_DIFF_TERM];
  assign ref_d.primary_diff_term = pri_diff_mode &
    ref_input_config_q[POS_PRIMARY_DIFF_TERM];
  assign ref_d.secondary_ac_bias =
    ref_input_config_q[POS_SECONDARY_AC_BIAS];
  assign ref_d.primary_ac_bias =
    ref_input_config_q[POS_PRIMARY_AC_BIAS];

  // Channel mux and divider power-down, one bit per channel
  wire [7:0] chan_off_d;
  wire       pair01;
  wire       pair23;

  assign pair01 = channel_power_down_q[POS_CHAN_PAIR_ZERO_ONE];
  assign pair23 = channel_power_down_q[POS_CHAN_PAIR_TWO_THREE];
  assign chan_off_d = {
    channel_power_down_q[POS_CHAN_SEVEN_OFF:POS_CHAN_FOUR_OFF],
    pair23, pair23,
    pair01, pair01
  };

  // Output 0 driver decode
  function automatic rioc_se_t se_dec(input logic [1:0] m);
    rioc_se_t s;
    s.on     = m[1];
    s.hiz    = (m == 2'b00);
    s.low    = (m == 2'b01);
    s.invert = (m == 2'b10);
    return s;
  endfunction

  function automatic logic [4:0] tail_dec(input logic [1:0] m,
                                          input logic       hcsl);
    logic [4:0] t;
    t = TAIL_MA_CODE2;
    case (m)
      2'b00:   t = TAIL_MA_CODE0;
      2'b01:   t = TAIL_MA_CODE1;
      2'b10:   t = TAIL_MA_CODE2;
      default: t = hcsl ? TAIL_MA_HCSL3 : TAIL_MA_CODE2;
    endcase
    return t;
  endfunction

  function automatic logic [7:0] load_dec(input logic [1:0] m);
    logic [7:0] r;
    r = 8'h00;
    case (m)
      2'b01:   r = LOAD_OHM_CODE1;
      2'b10:   r = LOAD_OHM_CODE2;
      2'b11:   r = LOAD_OHM_CODE3;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  localparam rioc_se_t SE_IDLE = '{on: 1'b0, hiz: 1'b1,
                                   low: 1'b0, invert: 1'b0};

  rioc_fmt_t  fmt;
  wire [1:0]  mode1;
  wire [1:0]  mode2;
  wire        is_diff;
  wire        is_hcsl;
  wire        is_cmos;
  rioc_out0_t out0_d;

  assign fmt = rioc_fmt_t'(
    output_zero_control_q[POS_FORMAT_LSB +: 2]);
  assign mode1 = output_zero_control_q[POS_MODE_FIRST_LSB +: 2];
  assign mode2 = output_zero_control_q[POS_MODE_SECOND_LSB +: 2];
  assign is_hcsl = (fmt == FMT_HCSL);
  assign is_diff = (fmt == FMT_AC_DIFF) | is_hcsl;
  assign is_cmos = (fmt == FMT_CMOS);

  assign out0_d.src_pll2 =
    output_zero_control_q[POS_PAIR_SOURCE_SELECT];
  // Format zero turns off the output buffer only; mux and divider follow the pair zero one bit
  assign out0_d.drv_on = (fmt != FMT_OFF);
  assign out0_d.fmt = fmt;
  assign out0_d.tail_ma = is_diff ?
    tail_dec(mode1, is_hcsl) : 5'h00;
  assign out0_d.load_ohm = is_hcsl ? load_dec(mode2) : 8'h00;
  assign out0_d.pos = is_cmos ? se_dec(mode1) : SE_IDLE;
  assign out0_d.neg = is_cmos ? se_dec(mode2) : SE_IDLE;

  // Decoded controls leave through flip-flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_ctrl_q                 <= '0;
      chan_mux_div_off_q         <= 8'h00;
      single_ended_channel_off_q <= 1'b0;
      out0_ctrl_q                <= '0;
    end else begin
      ref_ctrl_q                 <= ref_d;
      chan_mux_div_off_q         <= chan_off_d;
      single_ended_channel_off_q <=
        channel_power_down_q[POS_SINGLE_ENDED_OFF];
      out0_ctrl_q                <= out0_d;
    end
  end

  // Checks wait one edge after reset so flops show decoded values
  logic chk_live_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk_live_q <= 1'b0;
    end else begin
      chk_live_q <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn || !chk_live_q);

  a_bypass_valid: assert property (
    ref_input_config_q[POS_DETECTOR_BYPASS]
    |=> ref_ctrl_q.pri_valid && ref_ctrl_q.sec_valid)
    else $error("bypass did not force inputs valid");

  a_los_real: assert property (
    !pri_detect && !sec_detect
    |=> ref_ctrl_q.pri_los && ref_ctrl_q.sec_los)
    else $error("loss status not from detectors");

  a_sec_gnd_term: assert property (
    sec_diff_mode && ref_input_config_q[POS_SECONDARY_GROUND_TERM]
    |=> ref_ctrl_q.secondary_ground_term)
    else $error("secondary ground termination missing");

  a_pri_gnd_term: assert property (
    !pri_diff_mode |=> !ref_ctrl_q.primary_ground_term)
    else $error("primary ground termination outside diff mode");

  a_sec_diff_term: assert property (
    sec_diff_mode && ref_input_config_q[POS_SECONDARY_DIFF_TERM]
    |=> ref_ctrl_q.secondary_diff_term)
    else $error("secondary diff termination missing");

  a_pri_diff_term: assert property (
    pri_diff_mode && ref_input_config_q[POS_PRIMARY_DIFF_TERM]
    |=> ref_ctrl_q.primary_diff_term)
    else $error("primary diff termination missing");

  a_sec_ac_bias: assert property (
    !ref_input_config_q[POS_SECONDARY_AC_BIAS]
    |=> !ref_ctrl_q.secondary_ac_bias)
    else $error("secondary bias used while off");

  a_pri_ac_bias: assert property (
    ref_input_config_q[POS_PRIMARY_AC_BIAS]
    |=> ref_ctrl_q.primary_ac_bias)
    else $error("primary bias not enabled");

  a_chan_seven_off: assert property (
    hit_channel_power_down_wr && hwdata[POS_CHAN_SEVEN_OFF]
    |=> ##1 chan_mux_div_off_q[7])
    else $error("channel seven not disabled");

  a_pair_off: assert property (
    channel_power_down_q[POS_CHAN_PAIR_TWO_THREE]
    |=> chan_mux_div_off_q[3:2] == 2'b11)
    else $error("channel pair two three not disabled");

  a_se_chan_off: assert property (
    channel_power_down_q[POS_SINGLE_ENDED_OFF]
    |=> single_ended_channel_off_q)
    else $error("single-ended channel not off");

  a_source_select: assert property (
    !output_zero_control_q[POS_PAIR_SOURCE_SELECT]
    |=> !out0_ctrl_q.src_pll2)
    else $error("pair zero one not on first PLL");

  a_format_off: assert property (
    fmt == FMT_OFF |=> !out0_ctrl_q.drv_on && out0_ctrl_q.tail_ma == 5'h00)
    else $error("output zero driven while disabled");

  a_tail_hcsl: assert property (
    is_hcsl && mode1 == 2'b11 |=> out0_ctrl_q.tail_ma == TAIL_MA_HCSL3)
    else $error("hcsl tail current wrong");

  a_pos_pin: assert property (
    is_cmos && mode1 == 2'b10
    |=> out0_ctrl_q.pos.on && out0_ctrl_q.pos.invert)
    else $error("positive pin not inverted active");

  a_hcsl_load: assert property (
    is_hcsl && mode2 == 2'b11 |=> out0_ctrl_q.load_ohm == LOAD_OHM_CODE3)
    else $error("hcsl load not 200 ohm");

  a_neg_pin: assert property (
    is_cmos && mode2 == 2'b00
    |=> !out0_ctrl_q.neg.on && out0_ctrl_q.neg.hiz)
    else $error("negative pin not tri-stated");

  a_reserved_zero: assert property (
    hit_ref_wr |=> !ref_input_config_q[6] && hrdata[31:8] == 24'h000000)
    else $error("reserved bit stored");

  a_pri_gnd_set: assert property (
    pri_diff_mode && ref_input_config_q[POS_PRIMARY_GROUND_TERM]
    |=> ref_ctrl_q.primary_ground_term)
    else $error("primary ground termination missing");

  a_sec_gnd_off: assert property (
    !sec_diff_mode |=> !ref_ctrl_q.secondary_ground_term)
    else $error("secondary ground termination outside diff mode");

  a_pri_diff_off: assert property (
    !pri_diff_mode |=> !ref_ctrl_q.primary_diff_term)
    else $error("primary diff termination outside diff mode");

  a_sec_ac_set: assert property (
    ref_input_config_q[POS_SECONDARY_AC_BIAS]
    |=> ref_ctrl_q.secondary_ac_bias)
    else $error("secondary bias not enabled");

  a_los_bypass: assert property (
    ref_input_config_q[POS_DETECTOR_BYPASS] && pri_detect && !sec_detect
    |=> !ref_ctrl_q.pri_los && ref_ctrl_q.sec_los)
    else $error("bypass altered loss status");

  a_chan_four_off: assert property (
    channel_power_down_q[POS_CHAN_FOUR_OFF] |=> chan_mux_div_off_q[4])
    else $error("channel four not disabled");

  a_pair_zero_one: assert property (
    channel_power_down_q[POS_CHAN_PAIR_ZERO_ONE]
    |=> chan_mux_div_off_q[1:0] == 2'b11)
    else $error("channel pair zero one not disabled");

  a_source_pll2: assert property (
    output_zero_control_q[POS_PAIR_SOURCE_SELECT] |=> out0_ctrl_q.src_pll2)
    else $error("pair zero one not on second PLL");

  a_tail_ac_top: assert property (
    fmt == FMT_AC_DIFF && mode1 == 2'b11
    |=> out0_ctrl_q.tail_ma == TAIL_MA_CODE2)
    else $error("ac tail current wrong");

  a_neg_low: assert property (
    is_cmos && mode2 == 2'b01
    |=> !out0_ctrl_q.neg.on && out0_ctrl_q.neg.low)
    else $error("negative pin not held low");

  a_read_upper: assert property (
    acc_take && !hwrite |=> hrdata[31:8] == 24'h000000)
    else $error("reserved read bits not zero");

endmodule

// ===== hw/rioc_pkg.sv
// Register map, field layout and decoded control types of the bank
package rioc_pkg;

  localparam logic [7:0]  IDX_REF_INPUT_CONFIG     = 8'h1D;
  localparam logic [7:0]  IDX_CHANNEL_POWER_DOWN   = 8'h1E;
  localparam logic [7:0]  IDX_OUTPUT_ZERO_CONTROL  = 8'h1F;
  localparam logic [31:0] ADR_REF_INPUT_CONFIG     =
    {22'h000000, IDX_REF_INPUT_CONFIG, 2'b00};
  localparam logic [31:0] ADR_CHANNEL_POWER_DOWN   =
    {22'h000000, IDX_CHANNEL_POWER_DOWN, 2'b00};
  localparam logic [31:0] ADR_OUTPUT_ZERO_CONTROL  =
    {22'h000000, IDX_OUTPUT_ZERO_CONTROL, 2'b00};

  localparam logic [7:0]  RST_REF_INPUT_CONFIG     = 8'h00;
  localparam logic [7:0]  RST_CHANNEL_POWER_DOWN   = 8'h00;
  localparam logic [7:0]  RST_OUTPUT_ZERO_CONTROL  = 8'hB0;
  localparam logic [7:0]  MSK_REF_INPUT_CONFIG     = 8'hBF;
  localparam logic [7:0]  MSK_CHANNEL_POWER_DOWN   = 8'h7F;
  localparam logic [7:0]  MSK_OUTPUT_ZERO_CONTROL  = 8'hFE;

  localparam int POS_DETECTOR_BYPASS        = 7;
  localparam int POS_SECONDARY_GROUND_TERM  = 5;
  localparam int POS_PRIMARY_GROUND_TERM    = 4;
  localparam int POS_SECONDARY_DIFF_TERM    = 3;
  localparam int POS_PRIMARY_DIFF_TERM      = 2;
  localparam int POS_SECONDARY_AC_BIAS      = 1;
  localparam int POS_PRIMARY_AC_BIAS        = 0;

  localparam int POS_SINGLE_ENDED_OFF       = 6;
  localparam int POS_CHAN_SEVEN_OFF         = 5;
  localparam int POS_CHAN_FOUR_OFF          = 2;
  localparam int POS_CHAN_PAIR_TWO_THREE    = 1;
  localparam int POS_CHAN_PAIR_ZERO_ONE     = 0;

  localparam int POS_PAIR_SOURCE_SELECT     = 7;
  localparam int POS_FORMAT_LSB             = 5;
  localparam int POS_MODE_FIRST_LSB         = 3;
  localparam int POS_MODE_SECOND_LSB        = 1;

  localparam logic [4:0] TAIL_MA_CODE0      = 5'h04;
  localparam logic [4:0] TAIL_MA_CODE1      = 5'h06;
  localparam logic [4:0] TAIL_MA_CODE2      = 5'h08;
  localparam logic [4:0] TAIL_MA_HCSL3      = 5'h10;
  localparam logic [7:0] LOAD_OHM_CODE1     = 8'h32;
  localparam logic [7:0] LOAD_OHM_CODE2     = 8'h64;
  localparam logic [7:0] LOAD_OHM_CODE3     = 8'hC8;

  typedef enum logic [1:0] {
    FMT_OFF, FMT_AC_DIFF, FMT_HCSL, FMT_CMOS
  } rioc_fmt_t;

  typedef struct packed {
    logic pri_valid;
    logic sec_valid;
    logic pri_los;
    logic sec_los;
    logic primary_ground_term;
    logic secondary_ground_term;
    logic primary_diff_term;
    logic secondary_diff_term;
    logic primary_ac_bias;
    logic secondary_ac_bias;
  } rioc_ref_t;

  typedef struct packed {
    logic on;
    logic hiz;
    logic low;
    logic invert;
  } rioc_se_t;

  typedef struct packed {
    logic       src_pll2;
    logic       drv_on;
    rioc_fmt_t  fmt;
    logic [4:0] tail_ma;
    logic [7:0] load_ohm;
    rioc_se_t   pos;
    rioc_se_t   neg;
  } rioc_out0_t;

endpackage

// ===== tb/tb_top.sv
// Self-checking bench for the reference input and output zero bank
`timescale 1ns/10ps
module tb_top;
  import rioc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        pd, sd, pdm, sdm, se_off;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, a;
  logic [7:0]  chan_off, sh_ref, sh_pwd, sh_out;
  rioc_ref_t   ref_q;
  rioc_out0_t  out0_q;
  logic [31:0] adrs [4];
  int          mismatches, compares;
  wire logic   hready;

  assign hready = hreadyout;

  rioc_regs dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pri_detect(pd), .sec_detect(sd),
    .pri_diff_mode(pdm), .sec_diff_mode(sdm), .ref_ctrl_q(ref_q),
    .chan_mux_div_off_q(chan_off),
    .single_ended_channel_off_q(se_off), .out0_ctrl_q(out0_q)
  );

  always #2 hclk = ~hclk;

  task final_report;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("Error at %0t: bus wait ran out", $time);
      final_report();
    end
  endtask

  // One single word transfer; read data is taken at the data phase edge
  task xfer(input logic [31:0] ad, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= ad;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask

  function automatic logic [7:0] shadow(input logic [31:0] ad);
    if (ad == ADR_REF_INPUT_CONFIG) return sh_ref;
    if (ad == ADR_CHANNEL_POWER_DOWN) return sh_pwd;
    if (ad == ADR_OUTPUT_ZERO_CONTROL) return sh_out;
    return 8'h00;
  endfunction

  task wr(input logic [31:0] ad, input logic [31:0] d);
    xfer(ad, 1'b1, d);
    if (ad == ADR_REF_INPUT_CONFIG) sh_ref = d[7:0] & 8'hBF;
    if (ad == ADR_CHANNEL_POWER_DOWN) sh_pwd = d[7:0] & 8'h7F;
    if (ad == ADR_OUTPUT_ZERO_CONTROL) sh_out = d[7:0] & 8'hFE;
  endtask

  function automatic rioc_ref_t exp_ref(input logic [7:0] r);
    rioc_ref_t e;
    e.pri_valid             = pd | r[7];
    e.sec_valid             = sd | r[7];
    e.pri_los               = ~pd;
    e.sec_los               = ~sd;
    e.primary_ground_term   = r[4] & pdm;
    e.secondary_ground_term = r[5] & sdm;
    e.primary_diff_term     = r[2] & pdm;
    e.secondary_diff_term   = r[3] & sdm;
    e.primary_ac_bias       = r[0];
    e.secondary_ac_bias     = r[1];
    return e;
  endfunction

  function automatic rioc_se_t exp_pin(input logic [1:0] m);
    case (m)
      2'h0: return 4'h4;
      2'h1: return 4'h2;
      2'h2: return 4'h9;
      default: return 4'h8;
    endcase
  endfunction

  function automatic rioc_out0_t exp_out0(input logic [7:0] r);
    rioc_out0_t e;
    logic [1:0] f, m1, m2;
    f  = r[6:5];
    m1 = r[4:3];
    m2 = r[2:1];
    e = '0;
    e.src_pll2 = r[7];
    e.drv_on   = (f != 2'h0);
    e.fmt      = rioc_fmt_t'(f);
    e.pos      = 4'h4;
    e.neg      = 4'h4;
    if (f == 2'h1 || f == 2'h2) begin
      e.tail_ma = (m1 == 2'h0) ? 5'h04 : (m1 == 2'h1) ? 5'h06 :
                  (m1 == 2'h3 && f == 2'h2) ? 5'h10 : 5'h08;
    end
    if (f == 2'h2) begin
      e.load_ohm = (m2 == 2'h0) ? 8'h00 : (m2 == 2'h1) ? 8'h32 :
                   (m2 == 2'h2) ? 8'h64 : 8'hC8;
    end
    if (f == 2'h3) begin
      e.pos = exp_pin(m1);
      e.neg = exp_pin(m2);
    end
    return e;
  endfunction

  // Outputs follow the registers one edge after the write data edge
  task check_outs;
    logic [7:0] p;
    repeat (3) @(posedge hclk);
    p = sh_pwd;
    check(32'(ref_q), 32'(exp_ref(sh_ref)));
    check(32'(chan_off), {24'h0, p[5:2], p[1], p[1], p[0], p[0]});
    check(32'(se_off), {31'h0, p[6]});
    check(32'(out0_q), 32'(exp_out0(sh_out)));
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    {pd, sd, pdm, sdm} = 4'h0;
    mismatches = 0;
    compares = 0;
    sh_ref = 8'h00;
    sh_pwd = 8'h00;
    sh_out = 8'hB0;
    adrs = '{ADR_REF_INPUT_CONFIG, ADR_CHANNEL_POWER_DOWN,
             ADR_OUTPUT_ZERO_CONTROL, 32'h0000_0080};
    void'($urandom(32'h00F2));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    check_outs();
    xfer(ADR_REF_INPUT_CONFIG, 1'b0, 32'h0);
    check(rd, 32'h0000_0000);
    xfer(ADR_CHANNEL_POWER_DOWN, 1'b0, 32'h0);
    check(rd, 32'h0000_0000);
    xfer(ADR_OUTPUT_ZERO_CONTROL, 1'b0, 32'h0);
    check(rd, 32'h0000_00B0);
    // Bypass with both detectors silent: valid forced, loss still shown
    wr(ADR_REF_INPUT_CONFIG, 32'hFFFF_FF80);
    check_outs();
    // Format zero alone shuts output zero, power-down bit clear
    wr(ADR_CHANNEL_POWER_DOWN, 32'h0000_0000);
    wr(ADR_OUTPUT_ZERO_CONTROL, 32'h0000_0080);
    check_outs();
    check(32'(out0_q.drv_on), 32'h0);
    // Unmapped places take no write and read zero
    wr(32'h0000_0070, 32'hFFFF_FFFF);
    xfer(32'h0000_0070, 1'b0, 32'h0);
    check(rd, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      wr(ADR_CHANNEL_POWER_DOWN, 32'(1 << i));
      check_outs();
    end
    for (int i = 0; i < 256; i++) begin
      {pdm, sdm} <= 2'(i);
      wr(ADR_OUTPUT_ZERO_CONTROL, 32'(i));
      check_outs();
    end
    for (int i = 0; i < 80; i++) begin
      {pd, sd, pdm, sdm} <= 4'($urandom);
      a = adrs[$urandom_range(3)];
      wr(a, $urandom);
      xfer(a, 1'b0, 32'h0);
      check(rd, {24'h0, shadow(a)});
      check_outs();
    end
    final_report();
  end
endmodule
